// [rtl/elhb_bridge.sv]
// Endian handling stage of the processor-to-PCI host bridge and the PCI-to-VME bridge.
// Assumes one access per path per cycle, already decoded by target; one clock mclk.
// Contract
// - Big-endian mode swaps lanes processor to PCI and PCI to memory.
// - Little-endian mode reverse-rearranges addresses of processor accesses toward PCI.
// - Little-endian mode rearranges PCI-to-memory addresses; never swaps lanes.
// - Local registers, DRAM and flash always seen big-endian, untouched.
// - VME bridge swaps lanes both directions regardless of mode.
// - VME access: host swap then VME swap; transparent in big-endian.
`timescale 1ns/1ns
module elhb_bridge
  import elhb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       le_mode_pin,
  input  wire elhb_xfer_s cpu_req,
  input  wire elhb_tgt_e  cpu_tgt,
  input  wire elhb_xfer_s pci_req,
  input  wire elhb_xfer_s vme_req,
  output elhb_xfer_s      pci_out_r,
  output elhb_xfer_s      vme_out_r,
  output elhb_xfer_s      local_out_r,
  output elhb_xfer_s      mem_out_r,
  output elhb_xfer_s      vme_pci_out_r,
  output logic            le_mode_r
);
  // Mode strap comes from outside the clock domain
  logic le_meta_r;
  logic le_sync_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      le_meta_r <= 1'b0;
      le_sync_r <= 1'b0;
      le_mode_r <= 1'b0;
    end else begin
      le_meta_r <= le_mode_pin;
      le_sync_r <= le_meta_r;
      le_mode_r <= le_sync_r;
    end
  end

  function automatic logic [ELHB_AW-1:0] munge(input logic [ELHB_AW-1:0] a,
                                               input elhb_size_e sz);
    logic [1:0] m;
    m = ELHB_MUNGE_WORD;
    unique case (sz)
      ELHB_SZ_BYTE: m = ELHB_MUNGE_BYTE;
      ELHB_SZ_HALF: m = ELHB_MUNGE_HALF;
      ELHB_SZ_WORD: m = ELHB_MUNGE_WORD;
      default:      m = ELHB_MUNGE_WORD;
    endcase
    munge = {a[ELHB_AW-1:2], a[1:0] ^ m};
  endfunction

  // Host bridge swap applies only in big-endian mode
  logic             host_swap;
  logic [ELHB_DW-1:0] cpu_sw_d;
  logic [3:0]         cpu_sw_be;
  logic [ELHB_DW-1:0] pci_sw_d;
  logic [3:0]         pci_sw_be;
  logic [ELHB_DW-1:0] vme_sw_d;
  logic [3:0]         vme_sw_be;
  logic [ELHB_DW-1:0] vme_cpu_d;
  logic [3:0]         vme_cpu_be;

  assign host_swap = !le_mode_r;

  elhb_lane_swap u_cpu_swap (
    .swap_en  (host_swap),
    .data_in  (cpu_req.data),
    .be_in    (cpu_req.be),
    .data_out (cpu_sw_d),
    .be_out   (cpu_sw_be)
  );

  elhb_lane_swap u_pci_swap (
    .swap_en  (host_swap),
    .data_in  (pci_req.data),
    .be_in    (pci_req.be),
    .data_out (pci_sw_d),
    .be_out   (pci_sw_be)
  );

  // VME bridge swap never depends on the mode
  elhb_lane_swap u_vme_swap (
    .swap_en  (1'b1),
    .data_in  (vme_req.data),
    .be_in    (vme_req.be),
    .data_out (vme_sw_d),
    .be_out   (vme_sw_be)
  );

  // Processor data bound for VME: host stage output fed through the VME swap
  elhb_lane_swap u_cpu_vme_swap (
    .swap_en  (1'b1),
    .data_in  (cpu_sw_d),
    .be_in    (cpu_sw_be),
    .data_out (vme_cpu_d),
    .be_out   (vme_cpu_be)
  );

  logic [ELHB_AW-1:0] cpu_addr_fwd;
  logic [ELHB_AW-1:0] pci_addr_fwd;

  assign cpu_addr_fwd = le_mode_r ? munge(cpu_req.addr, cpu_req.size)
                                  : cpu_req.addr;
  assign pci_addr_fwd = le_mode_r ? munge(pci_req.addr, pci_req.size)
                                  : pci_req.addr;

  // Processor to PCI
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pci_out_r <= '0;
    end else begin
      pci_out_r       <= '0;
      pci_out_r.be    <= ELHB_BE_NONE;
      if (cpu_req.valid && cpu_tgt == ELHB_TGT_PCI) begin
        pci_out_r.valid <= 1'b1;
        pci_out_r.write <= cpu_req.write;
        pci_out_r.size  <= cpu_req.size;
        pci_out_r.addr  <= cpu_addr_fwd;
        pci_out_r.data  <= cpu_sw_d;
        pci_out_r.be    <= cpu_sw_be;
      end
    end
  end

  // Processor to VME: host stage then VME swap, net transparent in big-endian
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vme_out_r <= '0;
    end else begin
      vme_out_r <= '0;
      if (cpu_req.valid && cpu_tgt == ELHB_TGT_VME) begin
        vme_out_r.valid <= 1'b1;
        vme_out_r.write <= cpu_req.write;
        vme_out_r.size  <= cpu_req.size;
        vme_out_r.addr  <= cpu_addr_fwd;
        vme_out_r.data  <= vme_cpu_d;
        vme_out_r.be    <= vme_cpu_be;
      end
    end
  end

  // Local registers, DRAM, flash: passed as-is, always big-endian
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      local_out_r <= '0;
    end else begin
      local_out_r <= '0;
      if (cpu_req.valid && cpu_tgt == ELHB_TGT_LOCAL) begin
        local_out_r <= cpu_req;
      end
    end
  end

  // PCI to memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_out_r <= '0;
    end else begin
      mem_out_r <= '0;
      if (pci_req.valid) begin
        mem_out_r.valid <= 1'b1;
        mem_out_r.write <= pci_req.write;
        mem_out_r.size  <= pci_req.size;
        mem_out_r.addr  <= pci_addr_fwd;
        mem_out_r.data  <= pci_sw_d;
        mem_out_r.be    <= pci_sw_be;
      end
    end
  end

  // VME to PCI: unconditional swap, address kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vme_pci_out_r <= '0;
    end else begin
      vme_pci_out_r <= '0;
      if (vme_req.valid) begin
        vme_pci_out_r.valid <= 1'b1;
        vme_pci_out_r.write <= vme_req.write;
        vme_pci_out_r.size  <= vme_req.size;
        vme_pci_out_r.addr  <= vme_req.addr;
        vme_pci_out_r.data  <= vme_sw_d;
        vme_pci_out_r.be    <= vme_sw_be;
      end
    end
  end

  // Assertions
  a_be_pci_swap: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pci_out_r.valid) && !$past(le_mode_r) |->
      pci_out_r.data[7:0] == $past(cpu_req.data[31:24]))
    else $error("big-endian cpu to pci lanes not swapped");

  a_le_pci_munge: assert property (@(posedge mclk) disable iff (!rst_n)
    pci_out_r.valid && $past(le_mode_r) && $past(cpu_req.size) == ELHB_SZ_BYTE |->
      pci_out_r.addr[1:0] == ~$past(cpu_req.addr[1:0]))
    else $error("little-endian byte address not inverted");

  a_le_mem_noswap: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_out_r.valid && $past(le_mode_r) |->
      mem_out_r.data == $past(pci_req.data))
    else $error("little-endian pci to memory data swapped");

  a_le_mem_munge: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_out_r.valid && $past(le_mode_r) && $past(pci_req.size) == ELHB_SZ_HALF |->
      mem_out_r.addr[1] != $past(pci_req.addr[1]))
    else $error("little-endian half address not rearranged");

  a_local_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    local_out_r.valid |-> local_out_r == $past(cpu_req))
    else $error("local access altered");

  a_vme_pci_swap: assert property (@(posedge mclk) disable iff (!rst_n)
    vme_pci_out_r.valid |->
      vme_pci_out_r.data[31:24] == $past(vme_req.data[7:0]))
    else $error("vme to pci lanes not swapped");

  a_be_vme_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    vme_out_r.valid && !$past(le_mode_r) |->
      vme_out_r.data == $past(cpu_req.data))
    else $error("big-endian vme path not transparent");

  a_mode_sync: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(le_mode_r) |-> le_mode_r == $past(le_mode_pin, 3))
    else $error("mode not synchronised in three cycles");
endmodule // elhb_bridge

// [rtl/elhb_pkg.sv]
// Package for the endian lane handling bridge: modes, lane layout, carriers.
// Assumes 32-bit data lanes and byte-addressed accesses of 1, 2 or 4 bytes.
package elhb_pkg;
  localparam int unsigned ELHB_DW = 32;
  localparam int unsigned ELHB_AW = 32;

  typedef enum logic [1:0] {
    ELHB_SZ_BYTE,
    ELHB_SZ_HALF,
    ELHB_SZ_WORD
  } elhb_size_e;

  // Low address bits inverted per size in little-endian mode
  localparam logic [1:0] ELHB_MUNGE_BYTE = 2'h3;
  localparam logic [1:0] ELHB_MUNGE_HALF = 2'h2;
  localparam logic [1:0] ELHB_MUNGE_WORD = 2'h0;

  // Processor-side target classes
  typedef enum logic [1:0] {
    ELHB_TGT_PCI,
    ELHB_TGT_VME,
    ELHB_TGT_LOCAL
  } elhb_tgt_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    elhb_size_e        size;
    logic [ELHB_AW-1:0] addr;
    logic [ELHB_DW-1:0] data;
    logic [3:0]        be;
  } elhb_xfer_s;

  localparam logic [3:0] ELHB_BE_NONE = 4'h0;
endpackage : elhb_pkg

// [rtl/elhb_lane_swap.sv]
// Byte-lane swapper for one 32-bit lane with its byte enables.
// Assumes a plain combinational use inside a registered stage.
`timescale 1ns/1ns
module elhb_lane_swap
  import elhb_pkg::*;
(
  input  wire logic               swap_en,
  input  wire logic [ELHB_DW-1:0] data_in,
  input  wire logic [3:0]         be_in,
  output logic      [ELHB_DW-1:0] data_out,
  output logic      [3:0]         be_out
);
  // Byte 0 with 3, byte 1 with 2
  always_comb begin
    data_out = swap_en ? {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]}
                       : data_in;
    be_out   = swap_en ? {be_in[0], be_in[1], be_in[2], be_in[3]} : be_in;
  end
endmodule // elhb_lane_swap

// [test/elhb_far_agents.sv]
// Far-side agents: PCI masters into memory, VME masters toward PCI.
// Assumes the bench holds act low until reset is over.
`timescale 1ns/1ns
module elhb_far_agents
  import elhb_pkg::*;
#(
  parameter int SEED = 7
) (
  input  wire logic mclk,
  input  wire logic act,
  output elhb_xfer_s pci_req,
  output elhb_xfer_s vme_req
);
  integer seed = SEED;

  function automatic elhb_xfer_s rnd(inout integer s);
    elhb_xfer_s r;
    r.valid = 1'($random(s));
    r.write = 1'($random(s));
    r.size = elhb_size_e'($unsigned($random(s)) % 3);
    r.addr = $random(s);
    r.data = $random(s);
    r.be = 4'($random(s));
    return r;
  endfunction

  // Idle bus shows junk, so a stale copy can never pass for a result
  function automatic elhb_xfer_s idle(elhb_xfer_s x);
    elhb_xfer_s r;
    r = ~x;
    r.valid = 1'b0;
    return r;
  endfunction

  // Agents keep lane 0 as the lowest byte address
  always @(posedge mclk) begin
    pci_req <= act ? rnd(seed) : idle(pci_req);
    vme_req <= act ? rnd(seed) : idle(vme_req);
  end
endmodule // elhb_far_agents

// [test/tb.sv]
// Self-checking bench for the endian handling stage.
// Assumes one-cycle registered answers and a 3-flop mode sync.
`timescale 1ns/1ns
module tb;
  import elhb_pkg::*;
  logic       mclk = 0;
  logic       rst_n = 0;
  logic       le_mode_pin = 0;
  logic       act = 0;
  logic       le_mode_r;
  logic [2:0] m;
  elhb_xfer_s cpu_req = '0;
  elhb_tgt_e  cpu_tgt = ELHB_TGT_PCI;
  elhb_xfer_s pci_req, vme_req, pci_o, vme_o, loc_o, mem_o, vp_o;
  elhb_xfer_s e_pci, e_vme, e_loc, e_mem, e_vp;
  integer     seed = 25;
  integer     errors = 0;
  integer     checks_done = 0;

  always #20 mclk = ~mclk;

  elhb_far_agents #(.SEED(91)) agents (.mclk(mclk), .act(act), .pci_req(pci_req),
    .vme_req(vme_req));

  elhb_bridge dut (.mclk(mclk), .rst_n(rst_n), .le_mode_pin(le_mode_pin), .cpu_req(cpu_req),
    .cpu_tgt(cpu_tgt), .pci_req(pci_req), .vme_req(vme_req), .pci_out_r(pci_o),
    .vme_out_r(vme_o), .local_out_r(loc_o), .mem_out_r(mem_o), .vme_pci_out_r(vp_o),
    .le_mode_r(le_mode_r));

  function automatic elhb_xfer_s xf(elhb_xfer_s x, logic ok, logic sw, logic mg);
    elhb_xfer_s r;
    r = x;
    if (!(ok && x.valid)) return '0;
    if (sw) begin
      r.data = {x.data[7:0], x.data[15:8], x.data[23:16], x.data[31:24]};
      r.be = {x.be[0], x.be[1], x.be[2], x.be[3]};
    end
    if (mg)
      r.addr[1:0] = x.addr[1:0] ^ (x.size == ELHB_SZ_BYTE ? ELHB_MUNGE_BYTE :
                    x.size == ELHB_SZ_HALF ? ELHB_MUNGE_HALF : ELHB_MUNGE_WORD);
    return r;
  endfunction

  // Reference: mode seen three edges late, answers one edge late
  always @(posedge mclk or negedge rst_n) begin
    m <= rst_n ? {m[1:0], le_mode_pin} : 3'h0;
    e_pci <= xf(cpu_req, rst_n && cpu_tgt == ELHB_TGT_PCI, !m[2], m[2]);
    e_vme <= xf(cpu_req, rst_n && cpu_tgt == ELHB_TGT_VME, m[2], m[2]);
    e_loc <= xf(cpu_req, rst_n && cpu_tgt == ELHB_TGT_LOCAL, 1'b0, 1'b0);
    e_mem <= xf(pci_req, rst_n, !m[2], m[2]);
    e_vp <= xf(vme_req, rst_n, 1'b1, 1'b0);
  end

  task automatic chk(input logic [$bits(elhb_xfer_s)-1:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  always @(negedge mclk) begin
    chk(pci_o, e_pci);
    chk(vme_o, e_vme);
    chk(loc_o, e_loc);
    chk(mem_o, e_mem);
    chk(vp_o, e_vp);
    chk(le_mode_r, m[2]);
  end

  // Processor drives its bus in big-endian order whatever its mode
  task automatic burst(input string nm, input int n, input logic tog);
    elhb_xfer_s r;
    act <= 1'b1;
    repeat (n) begin
      @(posedge mclk);
      r.valid = 1'($random(seed));
      r.write = 1'($random(seed));
      r.size = elhb_size_e'($unsigned($random(seed)) % 3);
      r.addr = $random(seed);
      r.data = $random(seed);
      r.be = 4'($random(seed));
      cpu_req <= r;
      cpu_tgt <= elhb_tgt_e'($unsigned($random(seed)) % 3);
      if (tog && ($random(seed) & 7) == 0) le_mode_pin <= ~le_mode_pin;
    end
    $display("test %s done", nm);
  endtask

  // Every target with every size, back to back, odd base address
  task automatic corner(input string nm);
    act <= 1'b0;
    for (int t = 0; t < 3; t++) begin
      for (int s = 0; s < 3; s++) begin
        @(posedge mclk);
        cpu_req <= '{1'b1, 1'b1, elhb_size_e'(s), 32'h0000_1001 + s, 32'h1122_3344, 4'h1};
        cpu_tgt <= elhb_tgt_e'(t);
      end
    end
    @(posedge mclk);
    cpu_req <= '0;
    $display("test %s done", nm);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    burst("be_random", 200, 1'b0);
    corner("be_corner");
    le_mode_pin <= 1'b1;
    burst("le_random", 200, 1'b0);
    corner("le_corner");
    burst("mode_toggle", 300, 1'b1);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    burst("after_reset", 100, 1'b1);
    tally_and_finish;
  end

  // Run needs under 900 cycles; this limit leaves ample margin
  initial begin
    #(40 * 2000);
    errors++;
    tally_and_finish;
  end
endmodule // tb
